/* trip_pkg.sv */
package trip_pkg;

	// ----------------------------------------------------------------
	// Word layout
	// ----------------------------------------------------------------
	localparam int WORD_W    = 16;
	localparam int LOG_DEPTH = 10;

	typedef logic [WORD_W-1:0] fault_word_t;
	typedef fault_word_t [LOG_DEPTH-1:0] fault_log_t;

	// Bit of each trip source in every fault word
	localparam int FB_OVERSPEED     = 0;
	localparam int FB_MISSING_PULSE = 1;
	localparam int FB_FIELD_OVER_I  = 2;
	localparam int FB_HEATSINK      = 3;
	localparam int FB_THERMISTOR    = 4;
	localparam int FB_OVER_VOLTS    = 5;
	localparam int FB_SPEED_FBK     = 6;
	localparam int FB_ENCODER       = 7;
	localparam int FB_FIELD_FAIL    = 8;
	localparam int FB_SUPPLY_PHASE  = 9;
	localparam int FB_PHASE_LOCK    = 10;
	localparam int FB_LINK_RX_ERR   = 11;
	localparam int FB_STALL         = 12;
	localparam int FB_OVER_I        = 13;
	localparam int FB_MISC          = 14;
	localparam int FB_CT_FAIL       = 15;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam fault_word_t NO_ALARMS = 16'h0000;
	localparam logic        RUN_RST   = 1'b0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ           = 50_000_000;
	localparam int MS_PER_S         = 1000;
	localparam int MS_TICK_CYC      = CLK_HZ / MS_PER_S;
	localparam int DELAY_W          = 16;
	localparam int OVERSPEED_MS     = 50;
	localparam int MISSING_PULSE_MS = 60_000;
	localparam int DEFAULT_DELAY_MS = 1;

	// Status outputs travel together
	typedef struct packed {
		logic power_enable;
		logic ok_lamp;
		logic ok_output_terminal;
		logic alarm_shown;
	} status_t;

endpackage

/* trip_qualifier.sv */
`timescale 1ns/1ps
`default_nettype none
module trip_qualifier
	import trip_pkg::*;
#(
	parameter int CNT_W = DELAY_W
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Timing
	input  wire logic             ms_tick,
	input  wire logic [CNT_W-1:0] delay_ms,
	// Condition
	input  wire logic             cond,
	output logic                  qual_q
);

	logic [CNT_W-1:0] cnt_q;

	// Any drop of the condition restarts the whole delay
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (!cond) begin
			cnt_q <= '0;
		end else if (ms_tick && cnt_q < delay_ms) begin
			cnt_q <= cnt_q + CNT_W'(1);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			qual_q <= 1'b0;
		end else begin
			qual_q <= cond && (cnt_q >= delay_ms);
		end
	end

endmodule
`default_nettype wire

/* trip_latch_and_fault_log.sv */
`timescale 1ns/1ps
`default_nettype none
module trip_latch_and_fault_log
	import trip_pkg::*;
#(
	parameter int                              TICK_CYC = MS_TICK_CYC,
	parameter logic [WORD_W-1:0][DELAY_W-1:0] DELAY_MS = {
		{13{DELAY_W'(DEFAULT_DELAY_MS)}},
		DELAY_W'(DEFAULT_DELAY_MS),
		DELAY_W'(MISSING_PULSE_MS),
		DELAY_W'(OVERSPEED_MS)
	}
) (
	// Clock and power-up reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Raw trip conditions, one bit per source, and the miscellaneous trip code
	input  wire fault_word_t fault_cond,
	input  wire fault_word_t misc_code,
	// Start and run sequencing
	input  wire logic        run_request_input,
	input  wire logic        run_hold_input,
	input  wire logic        panel_run_key,
	input  wire logic        panel_stop_key,
	// Operator panel keys
	input  wire logic        ack_key,
	input  wire logic        down_key,
	// Status and records
	output status_t          status_q,
	output fault_word_t      active_fault_vector,
	output fault_word_t      first_fault_capture,
	output fault_word_t      latest_fault_code,
	output fault_log_t       fault_log
);

	localparam int TICK_W = $clog2(TICK_CYC + 1);

	// ----------------------------------------------------------------
	// Millisecond tick
	// ----------------------------------------------------------------
	logic [TICK_W-1:0] tick_cnt_q;
	logic              ms_tick_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_cnt_q <= '0;
			ms_tick_q  <= 1'b0;
		end else if (tick_cnt_q == TICK_W'(TICK_CYC - 1)) begin
			tick_cnt_q <= '0;
			ms_tick_q  <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + TICK_W'(1);
			ms_tick_q  <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Delay qualification per source
	// ----------------------------------------------------------------
	fault_word_t qual;

	// A transient that spans fewer ms ticks than its delay never reaches the latch
	for (genvar i = 0; i < WORD_W; i++) begin : g_qual
		trip_qualifier #(
			.CNT_W (DELAY_W)
		) u_qual (
			.clk      (clk),
			.rst      (rst),
			.ms_tick  (ms_tick_q),
			.delay_ms (DELAY_MS[i]),
			.cond     (fault_cond[i]),
			.qual_q   (qual[i])
		);
	end

	// ----------------------------------------------------------------
	// Start sequencing
	// ----------------------------------------------------------------
	logic panel_run_q;
	logic run_prev_q;
	logic run_now;
	logic start_rise;

	// Stop key wins so a stuck run key cannot hold the drive on
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			panel_run_q <= RUN_RST;
		end else if (panel_stop_key) begin
			panel_run_q <= 1'b0;
		end else if (panel_run_key) begin
			panel_run_q <= 1'b1;
		end
	end

	assign run_now = (run_request_input && run_hold_input) || panel_run_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			run_prev_q <= RUN_RST;
		end else begin
			run_prev_q <= run_now;
		end
	end

	// Run must be removed and reapplied before it counts as reset
	assign start_rise = run_now && !run_prev_q;

	// ----------------------------------------------------------------
	// Trip latch
	// ----------------------------------------------------------------
	fault_word_t latched_q;
	fault_word_t latched_d;
	fault_word_t new_ev;
	logic        trip_d;

	// Newly qualified sources, each on its own bit
	assign new_ev = qual & ~latched_q;

	always_comb begin
		latched_d = latched_q;
		if (start_rise) begin
			latched_d = latched_q & fault_cond;
		end
		latched_d = latched_d | qual;
	end

	assign trip_d = |latched_d;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			latched_q <= NO_ALARMS;
		end else begin
			latched_q <= latched_d;
		end
	end

	assign active_fault_vector = latched_q;

	// ----------------------------------------------------------------
	// Status outputs
	// ----------------------------------------------------------------
	// Acknowledge only hides the message; the latch ignores it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_q <= '0;
		end else begin
			status_q.power_enable       <= run_now && !trip_d;
			status_q.ok_lamp            <= !trip_d;
			status_q.ok_output_terminal <= !trip_d;
			if (|new_ev) begin
				status_q.alarm_shown <= 1'b1;
			end else if (ack_key) begin
				status_q.alarm_shown <= 1'b0;
			end else if (start_rise && !trip_d) begin
				status_q.alarm_shown <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// First fault, latest fault, log
	// ----------------------------------------------------------------
	// Simultaneous first trips are kept together as a sum of bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			first_fault_capture <= NO_ALARMS;
		end else if (start_rise) begin
			// A trip that qualifies on the restart edge itself is still the first one
			first_fault_capture <= (latched_d == new_ev) ? new_ev : NO_ALARMS;
		end else if (latched_q == NO_ALARMS && |new_ev) begin
			first_fault_capture <= new_ev;
		end
	end

	// An event in the cycle of a down key press is kept
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			latest_fault_code <= NO_ALARMS;
		end else if (|new_ev) begin
			latest_fault_code <= new_ev[FB_MISC] ? misc_code : new_ev;
		end else if (down_key) begin
			latest_fault_code <= NO_ALARMS;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fault_log <= '0;
		end else if (|new_ev) begin
			for (int k = LOG_DEPTH - 1; k > 0; k--) begin
				fault_log[k] <= fault_log[k-1];
			end
			fault_log[0] <= new_ev;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	trip_disable_a: assert property (@(posedge clk) disable iff (rst)
		(|qual) |=> !status_q.power_enable)
		else $error("power stage still enabled after trip");

	latch_hold_a: assert property (@(posedge clk) disable iff (rst)
		!start_rise |=> ((latched_q & $past(latched_q)) == $past(latched_q)))
		else $error("latched trip lost without reset");

	// The lamp is dark while reset holds, so the edges around release are skipped
	lamp_off_a: assert property (@(posedge clk) disable iff (rst)
		!$past(rst) |-> (status_q.ok_lamp == (latched_q == NO_ALARMS)))
		else $error("ok lamp disagrees with latch");

	terminal_low_a: assert property (@(posedge clk) disable iff (rst)
		(|latched_q) |-> !status_q.ok_output_terminal)
		else $error("ok terminal high during trip");

	ack_no_restart_a: assert property (@(posedge clk) disable iff (rst)
		(ack_key && |latched_q && !start_rise) |=> (|latched_q) && !status_q.power_enable)
		else $error("acknowledge affected latch");

	no_restart_a: assert property (@(posedge clk) disable iff (rst)
		status_q.power_enable |-> (latched_q == NO_ALARMS))
		else $error("power enabled with trip latched");

	selective_clear_a: assert property (@(posedge clk) disable iff (rst)
		start_rise |=> ((latched_q & $past(latched_q & fault_cond))
			== $past(latched_q & fault_cond)))
		else $error("persisting trip was cleared");

	first_hold_a: assert property (@(posedge clk) disable iff (rst)
		(first_fault_capture != NO_ALARMS && !start_rise) |=> $stable(first_fault_capture))
		else $error("first fault capture overwritten");

	first_clear_a: assert property (@(posedge clk) disable iff (rst)
		(start_rise && new_ev == NO_ALARMS) |=> first_fault_capture == NO_ALARMS)
		else $error("first fault capture not cleared on start");

	down_clear_a: assert property (@(posedge clk) disable iff (rst)
		(down_key && new_ev == NO_ALARMS) |=> latest_fault_code == NO_ALARMS)
		else $error("latest fault not cleared by down key");

	log_shift_a: assert property (@(posedge clk) disable iff (rst)
		(|new_ev) |=> (fault_log[1] == $past(fault_log[0]))
			&& (fault_log[0] == $past(new_ev)))
		else $error("fault log did not shift");

	late_trip_a: assert property (@(posedge clk) disable iff (rst)
		(|latched_q && |qual) |=> ((latched_q & $past(qual)) == $past(qual)))
		else $error("trip after stop not latched");

	power_drop_a: assert property (@(posedge clk) disable iff (rst)
		!run_now |=> !status_q.power_enable)
		else $error("power enabled without run");

	clear_free_a: assert property (@(posedge clk) disable iff (rst)
		start_rise |=> ((latched_q & $past(~fault_cond & ~qual)) == NO_ALARMS))
		else $error("ended trip not cleared on restart");

	power_on_a: assert property (@(posedge clk) disable iff (rst)
		(run_now && latched_d == NO_ALARMS) |=> status_q.power_enable)
		else $error("power not enabled with run and no trip");

	relight_a: assert property (@(posedge clk) disable iff (rst)
		(start_rise && latched_d == NO_ALARMS)
			|=> status_q.ok_lamp && status_q.ok_output_terminal && !status_q.alarm_shown)
		else $error("lamp or view not restored after reset");

	ack_clear_a: assert property (@(posedge clk) disable iff (rst)
		(ack_key && new_ev == NO_ALARMS) |=> !status_q.alarm_shown)
		else $error("acknowledge left alarm shown");

	shown_hold_a: assert property (@(posedge clk) disable iff (rst)
		(status_q.alarm_shown && !ack_key && !start_rise) |=> status_q.alarm_shown)
		else $error("alarm message dropped without cause");

	alarm_show_a: assert property (@(posedge clk) disable iff (rst)
		(|new_ev && !new_ev[FB_MISC])
			|=> status_q.alarm_shown && (latest_fault_code == $past(new_ev)))
		else $error("new trip not shown or recorded");

	misc_latest_a: assert property (@(posedge clk) disable iff (rst)
		new_ev[FB_MISC] |=> (latest_fault_code == $past(misc_code)))
		else $error("miscellaneous trip code not recorded");

	first_take_a: assert property (@(posedge clk) disable iff (rst)
		(|new_ev && latched_d == new_ev) |=> (first_fault_capture == $past(new_ev)))
		else $error("first fault not captured");

	own_bit_a: assert property (@(posedge clk) disable iff (rst)
		(|new_ev) |=> ((active_fault_vector & $past(new_ev)) == $past(new_ev)))
		else $error("new trip bit missing from vector");

	// Holds only while every delay is at least one tick; a zero delay passes single edges
	qual_cause_a: assert property (@(posedge clk) disable iff (rst)
		((qual & ~$past(qual)) & ~($past(fault_cond) & $past(fault_cond, 2))) == NO_ALARMS)
		else $error("trip qualified without a held condition");

	log_deep_a: assert property (@(posedge clk) disable iff (rst)
		(|new_ev) |=> (fault_log[LOG_DEPTH-1] == $past(fault_log[LOG_DEPTH-2])))
		else $error("oldest log entry not shifted");

	log_still_a: assert property (@(posedge clk) disable iff (rst)
		(new_ev == NO_ALARMS) |=> $stable(fault_log))
		else $error("fault log changed without an event");

	// ----------------------------------------------------------------
	// Coverage
	// ----------------------------------------------------------------
	trip_cover_c: cover property (@(posedge clk) disable iff (rst)
		status_q.power_enable ##1 !status_q.power_enable && |latched_q);

	reset_cover_c: cover property (@(posedge clk) disable iff (rst)
		(|latched_q) ##1 start_rise ##1 (latched_q == NO_ALARMS));

	late_trip_cover_c: cover property (@(posedge clk) disable iff (rst)
		(|latched_q && !status_q.power_enable && |new_ev));

	log_full_cover_c: cover property (@(posedge clk) disable iff (rst)
		fault_log[LOG_DEPTH-1] != NO_ALARMS);

	multi_trip_cover_c: cover property (@(posedge clk) disable iff (rst)
		(|new_ev) && !$onehot(new_ev));

endmodule
`default_nettype wire

/* op_panel.sv */
`timescale 1ns/1ps
`default_nettype none
module op_panel (
	// Clock
	input  wire logic clk,
	// Run terminals
	output logic      run_request_input,
	output logic      run_hold_input,
	// Keypad
	output logic      panel_run_key,
	output logic      panel_stop_key,
	output logic      ack_key,
	output logic      down_key
);
	initial begin
		run_request_input = 1'b0;
		run_hold_input = 1'b0;
		{panel_run_key, panel_stop_key, ack_key, down_key} = 4'h0;
	end

	// Hold stays up as a steady interlock; only the request toggles
	task automatic term_run(input logic on);
		@(posedge clk);
		run_request_input <= on;
		run_hold_input <= 1'b1;
	endtask

	// Dropping the hold alone must stop a terminal run
	task automatic term_hold(input logic on);
		@(posedge clk);
		run_hold_input <= on;
	endtask

	// Key index: 0 run, 1 stop, 2 acknowledge, 3 down; one clock per press
	task automatic press(input int key);
		@(posedge clk);
		panel_run_key <= (key == 0);
		panel_stop_key <= (key == 1);
		ack_key <= (key == 2);
		down_key <= (key == 3);
		@(posedge clk);
		{panel_run_key, panel_stop_key, ack_key, down_key} <= 4'h0;
	endtask
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
	import trip_pkg::*;
;
	// ----------------------------------------------------------------
	// Bench setup
	// ----------------------------------------------------------------
	localparam int TICK = 4;
	localparam int WAIT_TRIP = 2 * TICK + 4;
	localparam int LIMIT = 5000;
	logic        clk;
	logic        rst;
	fault_word_t fault_cond;
	fault_word_t misc_code;
	logic        run_request_input;
	logic        run_hold_input;
	logic        panel_run_key;
	logic        panel_stop_key;
	logic        ack_key;
	logic        down_key;
	status_t     status_q;
	fault_word_t active_fault_vector;
	fault_word_t first_fault_capture;
	fault_word_t latest_fault_code;
	fault_log_t  fault_log;
	int          err_total = 0;
	int          n_tests = 0;
	int          cycles = 0;

	// Short tick and one-tick delays keep qualification within a dozen cycles
	trip_latch_and_fault_log #(.TICK_CYC(TICK), .DELAY_MS({WORD_W{16'h0001}})) i_trip_latch_and_fault_log (
		.clk(clk), .rst(rst), .fault_cond(fault_cond), .misc_code(misc_code),
		.run_request_input(run_request_input), .run_hold_input(run_hold_input),
		.panel_run_key(panel_run_key), .panel_stop_key(panel_stop_key),
		.ack_key(ack_key), .down_key(down_key), .status_q(status_q),
		.active_fault_vector(active_fault_vector), .first_fault_capture(first_fault_capture),
		.latest_fault_code(latest_fault_code), .fault_log(fault_log));
	op_panel i_op_panel (
		.clk(clk), .run_request_input(run_request_input), .run_hold_input(run_hold_input),
		.panel_run_key(panel_run_key), .panel_stop_key(panel_stop_key),
		.ack_key(ack_key), .down_key(down_key));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			err_total++;
			close_out();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk_bit(input string name, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %b, seen %b", name, exp, got);
		end
	endtask

	task automatic chk_word(input string name, input fault_word_t exp, input fault_word_t got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	task automatic chk_stat(input logic pe, input logic lamp, input logic term, input logic shown);
		chk_bit("power_enable", pe, status_q.power_enable);
		chk_bit("ok_lamp", lamp, status_q.ok_lamp);
		chk_bit("ok_output_terminal", term, status_q.ok_output_terminal);
		chk_bit("alarm_shown", shown, status_q.alarm_shown);
	endtask

	task automatic chk_vec(input fault_word_t act, input fault_word_t first);
		chk_word("active_fault_vector", act, active_fault_vector);
		chk_word("first_fault_capture", first, first_fault_capture);
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic set_cond(input int b, input logic v);
		@(posedge clk);
		fault_cond[b] <= v;
		step(WAIT_TRIP);
	endtask

	// Panel stop then run: the panel latch keeps run asserted afterwards
	task automatic rerun();
		i_op_panel.press(1);
		i_op_panel.press(0);
		step(3);
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		fault_cond = '0;
		misc_code = '0;
		step(7);
		chk_stat(0, 0, 0, 0);
		@(posedge clk);
		rst <= 1'b0;
		step(2);
		chk_stat(0, 1, 1, 0);
		chk_vec(16'h0000, 16'h0000);
		i_op_panel.term_run(1'b1);
		step(3);
		chk_stat(1, 1, 1, 0);
		@(posedge clk);
		fault_cond[4] <= 1'b1;
		@(posedge clk);
		fault_cond[4] <= 1'b0;
		step(WAIT_TRIP);
		chk_vec(16'h0000, 16'h0000);
		chk_bit("power_enable", 1'b1, status_q.power_enable);
		set_cond(3, 1'b1);
		chk_stat(0, 0, 0, 1);
		chk_vec(16'h0008, 16'h0008);
		chk_word("latest_fault_code", 16'h0008, latest_fault_code);
		set_cond(3, 1'b0);
		chk_vec(16'h0008, 16'h0008);
		chk_bit("power_enable", 1'b0, status_q.power_enable);
		set_cond(5, 1'b1);
		chk_vec(16'h0028, 16'h0008);
		chk_word("latest_fault_code", 16'h0020, latest_fault_code);
		chk_word("fault_log0", 16'h0020, fault_log[0]);
		chk_word("fault_log1", 16'h0008, fault_log[1]);
		i_op_panel.press(2);
		step(1);
		chk_stat(0, 0, 0, 0);
		chk_vec(16'h0028, 16'h0008);
		i_op_panel.term_run(1'b0);
		i_op_panel.term_run(1'b1);
		step(3);
		chk_vec(16'h0020, 16'h0000);
		chk_stat(0, 0, 0, 0);
		set_cond(5, 1'b0);
		i_op_panel.term_run(1'b0);
		rerun();
		chk_stat(1, 1, 1, 0);
		chk_vec(16'h0000, 16'h0000);
		i_op_panel.press(3);
		step(1);
		chk_word("latest_fault_code", 16'h0000, latest_fault_code);
		i_op_panel.press(1);
		i_op_panel.term_run(1'b1);
		step(3);
		chk_bit("power_enable", 1'b1, status_q.power_enable);
		i_op_panel.term_hold(1'b0);
		step(3);
		chk_bit("power_enable", 1'b0, status_q.power_enable);
		i_op_panel.term_hold(1'b1);
		step(3);
		chk_stat(1, 1, 1, 0);
		i_op_panel.term_run(1'b0);
		@(posedge clk);
		misc_code <= 16'hf003;
		set_cond(14, 1'b1);
		chk_word("latest_fault_code", 16'hf003, latest_fault_code);
		chk_vec(16'h4000, 16'h4000);
		set_cond(14, 1'b0);
		rerun();
		chk_stat(1, 1, 1, 0);
		for (int b = 0; b <= 10; b++) begin
			set_cond(b, 1'b1);
			set_cond(b, 1'b0);
			rerun();
		end
		for (int i = 0; i < LOG_DEPTH; i++) begin
			chk_word("fault_log", fault_word_t'(16'h0001 << (10 - i)), fault_log[i]);
		end
		@(posedge clk);
		misc_code <= 16'hff03;
		fault_cond <= 16'hf800;
		step(WAIT_TRIP);
		chk_vec(16'hf800, 16'hf800);
		chk_word("latest_fault_code", 16'hff03, latest_fault_code);
		chk_word("fault_log0", 16'hf800, fault_log[0]);
		chk_word("fault_log1", 16'h0400, fault_log[1]);
		@(posedge clk);
		fault_cond <= 16'h0004;
		step(WAIT_TRIP);
		chk_vec(16'hf804, 16'hf800);
		@(posedge clk);
		rst <= 1'b1;
		step(1);
		chk_stat(0, 0, 0, 0);
		chk_vec(16'h0000, 16'h0000);
		chk_word("fault_log0", 16'h0000, fault_log[0]);
		@(posedge clk);
		rst <= 1'b0;
		step(1);
		chk_stat(0, 1, 1, 0);
		step(WAIT_TRIP);
		chk_vec(16'h0004, 16'h0004);
		chk_stat(0, 0, 0, 1);
		close_out();
	end
endmodule
`default_nettype wire
